// ---- rtl/gpf_pkg.sv ----
// Package with constants, register map and carrier types of the pin interrupt and mux controller
package gpf_pkg;

    localparam int NPORT    = 4;
    localparam int PWIDTH   = 32;
    localparam int NPIN     = NPORT * PWIDTH;
    localparam int NFUNC    = 4;
    localparam int GRPSIZE  = 8;
    localparam int NIRQ     = NPIN / GRPSIZE;
    localparam int WB_AW    = 10;
    localparam int GF_LEN   = 3;

    // Register group offsets within one port window
    localparam logic [7:0] OFF_SW_CTRL   = 8'h00;
    localparam logic [7:0] OFF_PSEL_LO   = 8'h10;
    localparam logic [7:0] OFF_PSEL_HI   = 8'h20;
    localparam logic [7:0] OFF_DRV_EN    = 8'h40;
    localparam logic [7:0] OFF_OUT_VAL   = 8'h50;
    localparam logic [7:0] OFF_PIN_VAL   = 8'h60;
    localparam logic [7:0] OFF_IRQ_EN    = 8'h90;
    localparam logic [7:0] OFF_MODE_LO   = 8'hA0;
    localparam logic [7:0] OFF_MODE_HI   = 8'hB0;
    localparam logic [7:0] OFF_GF_EN     = 8'hC0;
    localparam logic [7:0] OFF_FLAGS     = 8'hD0;
    localparam logic [7:0] OFF_FLAGS_CLR = 8'hD8;

    // Access kind within a group, taken from address bits 3:2
    localparam logic [1:0] SUB_RW  = 2'h0;
    localparam logic [1:0] SUB_SET = 2'h1;
    localparam logic [1:0] SUB_CLR = 2'h2;
    localparam logic [1:0] SUB_TGL = 2'h3;

    // Interrupt mode codes, high bit first
    localparam logic [1:0] MODE_CHANGE = 2'h0;
    localparam logic [1:0] MODE_RISE   = 2'h1;
    localparam logic [1:0] MODE_FALL   = 2'h2;

    // Reset values of software control enable and glitch filter enable
    localparam logic [31:0] RST_EN_P02 = 32'h0FFF_FFFF;
    localparam logic [31:0] RST_EN_P3  = 32'h0000_7FFF;
    localparam logic [NPIN-1:0] RST_EN = {RST_EN_P3, RST_EN_P02, RST_EN_P02, RST_EN_P02};

    typedef struct packed {
        logic [NFUNC-1:0][NPIN-1:0] dout;
        logic [NFUNC-1:0][NPIN-1:0] den;
    } gpf_periph_s;

endpackage

// ---- rtl/gpf_top.sv ----
// Pin interrupt detection, glitch filter, peripheral mux and Wishbone register file for four ports
//
// Functional notes
// - Mode bits decode high first as 00 any change, 01 rising edge, 10 falling edge; 11 is reserved.
// - A pin whose filter-enable bit is one is detected through the glitch filter, otherwise directly.
// - Filter enable sits at four words: read/write, set-by-ones, clear-by-ones, toggle-by-ones.
// - A pin's flag sets on its detected condition, stays until cleared, and is zero after reset.
// - The flag register reads at its base word and is cleared by ones at the third word, nothing else.
// - A flag is meaningful only while the pin's interrupt enable is one.
// - The number of interrupt request outputs scales with the number of pins.
// - Four 32-bit ports, identical except for port 3's reset enables, each pin selectable among four peripheral functions.
// - All registers reset to zero except software control and filter enables, per port as given, and pin_oe_b, which resets to ones.
// - Detection for a pin is enabled only while its interrupt enable bit is one.
// - The low mode bit comes from its own register with the same set, clear and toggle scheme.
`timescale 1ns/1ns
`default_nettype none

module gpf_top
(
    input  wire logic                        clk_sys,
    input  wire logic                        rst_b,
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [gpf_pkg::WB_AW-1:0]   wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output logic      [31:0]                 wb_dat_o,
    output logic                             wb_ack_o,
    input  wire logic [gpf_pkg::NPIN-1:0]    pin_in,
    output logic      [gpf_pkg::NPIN-1:0]    pin_out,
    output logic      [gpf_pkg::NPIN-1:0]    pin_oe_b,
    input  wire gpf_pkg::gpf_periph_s        periph_i,
    output logic      [gpf_pkg::NPIN-1:0]    periph_din,
    output logic      [gpf_pkg::NIRQ-1:0]    irq_o
);
    import gpf_pkg::*;

    typedef struct packed {
        logic [NPIN-1:0]             sw_ctrl;
        logic [NPIN-1:0]             psel_lo;
        logic [NPIN-1:0]             psel_hi;
        logic [NPIN-1:0]             drv_en;
        logic [NPIN-1:0]             out_val;
        logic [NPIN-1:0]             irq_en;
        logic [NPIN-1:0]             irq_mode_low_bits;
        logic [NPIN-1:0]             irq_mode_high_bits;
        logic [NPIN-1:0]             gf_en;
        logic [NPIN-1:0]             flags;
        logic [NPIN-1:0]             sync1;
        logic [NPIN-1:0]             sync2;
        logic [GF_LEN-1:0][NPIN-1:0] hist;
        logic [NPIN-1:0]             filt;
        logic [NPIN-1:0]             prev;
        logic [NPIN-1:0]             pin_out;
        logic [NPIN-1:0]             pin_oe_b;
        logic [NPIN-1:0]             pdin;
        logic [NIRQ-1:0]             irq;
        logic                        ack;
        logic [31:0]                 dat;
    } gpf_state_s;

    gpf_state_s q;
    gpf_state_s d;

    // Combinational views, also watched by the assertions
    logic [NPIN-1:0] det;
    logic [NPIN-1:0] rise;
    logic [NPIN-1:0] fall;
    logic [NPIN-1:0] chg;
    logic [NPIN-1:0] hit;
    logic [NPIN-1:0] clr_v;
    logic [NPIN-1:0] all1;
    logic [NPIN-1:0] all0;
    logic            req;
    logic            wr;
    logic [6:0]      pb;
    logic [7:0]      grp;
    logic [7:0]      off;
    logic [1:0]      sub;
    logic [31:0]     wm;
    logic [31:0]     rdata;

    function automatic logic [31:0] upd(input logic [31:0] cur, input logic [31:0] wd,
                                        input logic [31:0] m, input logic [1:0] s);
        logic [31:0] r;
        r = cur;
        case (s)
            SUB_RW:  r = (cur & ~m) | (wd & m);
            SUB_SET: r = cur | (wd & m);
            SUB_CLR: r = cur & ~(wd & m);
            default: r = cur ^ (wd & m);
        endcase
        return r;
    endfunction

    always_comb begin
        d     = q;
        req   = wb_cyc_i & wb_stb_i;
        // Writes commit on the edge at which the master samples ack
        wr    = req & wb_we_i & q.ack;
        pb    = {wb_adr_i[9:8], 5'h00};
        off   = wb_adr_i[7:0];
        grp   = {wb_adr_i[7:4], 4'h0};
        sub   = wb_adr_i[3:2];
        wm    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        clr_v = '0;
        rdata = 32'h0000_0000;

        // Pin synchroniser; the first stage feeds only the second
        d.sync1 = pin_in;
        d.sync2 = q.sync1;

        // Filter: level passes only after GF_LEN equal samples
        d.hist = {q.hist[GF_LEN-2:0], q.sync2};
        all1 = '1;
        all0 = '1;
        for (int k = 0; k < GF_LEN; k++) begin
            all1 = all1 & q.hist[k];
            all0 = all0 & ~q.hist[k];
        end
        d.filt = all1 | (q.filt & ~all0);

        det    = (q.gf_en & q.filt) | (~q.gf_en & q.sync2);
        d.prev = det;
        rise   = det & ~q.prev;
        fall   = ~det & q.prev;
        chg    = det ^ q.prev;
        // Reserved code 11 raises nothing
        hit    = q.irq_en & (
                 (~q.irq_mode_high_bits & ~q.irq_mode_low_bits & chg)  |
                 (~q.irq_mode_high_bits &  q.irq_mode_low_bits & rise) |
                 ( q.irq_mode_high_bits & ~q.irq_mode_low_bits & fall));

        // Read path, sampled into the data register on the same edge that raises ack
        case (grp)
            OFF_SW_CTRL: rdata = q.sw_ctrl[pb +: 32];
            OFF_PSEL_LO: rdata = q.psel_lo[pb +: 32];
            OFF_PSEL_HI: rdata = q.psel_hi[pb +: 32];
            OFF_DRV_EN:  rdata = q.drv_en[pb +: 32];
            OFF_OUT_VAL: rdata = q.out_val[pb +: 32];
            // Level is only visible for pins under software control or with interrupt enabled
            OFF_PIN_VAL: rdata = (sub == SUB_RW) ? (q.sync2[pb +: 32] & (q.sw_ctrl[pb +: 32] | q.irq_en[pb +: 32]))
                                                 : 32'h0000_0000;
            OFF_IRQ_EN:  rdata = q.irq_en[pb +: 32];
            OFF_MODE_LO: rdata = q.irq_mode_low_bits[pb +: 32];
            OFF_MODE_HI: rdata = q.irq_mode_high_bits[pb +: 32];
            OFF_GF_EN:   rdata = q.gf_en[pb +: 32];
            OFF_FLAGS:   rdata = (off == OFF_FLAGS) ? q.flags[pb +: 32] : 32'h0000_0000;
            default:     rdata = 32'h0000_0000;
        endcase

        d.ack = req & ~q.ack;
        if (d.ack) begin
            d.dat = rdata;
        end

        if (wr) begin
            case (grp)
                OFF_SW_CTRL: d.sw_ctrl[pb +: 32] = upd(q.sw_ctrl[pb +: 32], wb_dat_i, wm, sub);
                OFF_PSEL_LO: d.psel_lo[pb +: 32] = upd(q.psel_lo[pb +: 32], wb_dat_i, wm, sub);
                OFF_PSEL_HI: d.psel_hi[pb +: 32] = upd(q.psel_hi[pb +: 32], wb_dat_i, wm, sub);
                OFF_DRV_EN:  d.drv_en[pb +: 32] = upd(q.drv_en[pb +: 32], wb_dat_i, wm, sub);
                OFF_OUT_VAL: d.out_val[pb +: 32] = upd(q.out_val[pb +: 32], wb_dat_i, wm, sub);
                OFF_IRQ_EN:  d.irq_en[pb +: 32] = upd(q.irq_en[pb +: 32], wb_dat_i, wm, sub);
                OFF_MODE_LO: d.irq_mode_low_bits[pb +: 32] =
                                 upd(q.irq_mode_low_bits[pb +: 32], wb_dat_i, wm, sub);
                OFF_MODE_HI: d.irq_mode_high_bits[pb +: 32] =
                                 upd(q.irq_mode_high_bits[pb +: 32], wb_dat_i, wm, sub);
                // Changing this with interrupts enabled can fake an edge; software avoids it
                OFF_GF_EN:   d.gf_en[pb +: 32] = upd(q.gf_en[pb +: 32], wb_dat_i, wm, sub);
                OFF_FLAGS: begin
                    if (off == OFF_FLAGS_CLR) begin
                        clr_v[pb +: 32] = wb_dat_i & wm;
                    end
                end
                default: begin
                end
            endcase
        end

        // A detection in the same cycle as a clear keeps the flag set
        d.flags = (q.flags & ~clr_v) | hit;

        for (int g = 0; g < NIRQ; g++) begin
            d.irq[g] = |(q.flags[g*GRPSIZE +: GRPSIZE] & q.irq_en[g*GRPSIZE +: GRPSIZE]);
        end

        // Software control overrides the selected peripheral function
        for (int i = 0; i < NPIN; i++) begin
            if (q.sw_ctrl[i]) begin
                d.pin_out[i]  = q.out_val[i];
                d.pin_oe_b[i] = ~q.drv_en[i];
            end else begin
                d.pin_out[i]  = periph_i.dout[{q.psel_hi[i], q.psel_lo[i]}][i];
                d.pin_oe_b[i] = ~periph_i.den[{q.psel_hi[i], q.psel_lo[i]}][i];
            end
        end
        d.pdin = q.sync2;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            q          <= '0;
            q.sw_ctrl  <= RST_EN;
            q.gf_en    <= RST_EN;
            q.pin_oe_b <= '1;
        end else begin
            q <= d;
        end
    end

    assign wb_dat_o   = q.dat;
    assign wb_ack_o   = q.ack;
    assign pin_out    = q.pin_out;
    assign pin_oe_b   = q.pin_oe_b;
    assign periph_din = q.pdin;
    assign irq_o      = q.irq;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    flag_sets_a: assert property (hit != '0 |=> (q.flags & $past(hit)) == $past(hit))
        else $error("detected condition did not set its flag");

    flag_sticky_a: assert property ((($past(q.flags) & ~q.flags) != '0) |-> $past(wr) && $past(off) == OFF_FLAGS_CLR)
        else $error("flag fell without a clear write");

    flag_enable_a: assert property ((q.flags & ~$past(q.flags) & ~$past(q.irq_en)) == '0)
        else $error("flag set on a pin with interrupt disabled");

    mode_rise_a: assert property ((hit & ~q.irq_mode_high_bits & q.irq_mode_low_bits & ~(det & ~q.prev)) == '0)
        else $error("rising mode fired without a rising edge");

    mode_resv_a: assert property ((hit & q.irq_mode_high_bits & q.irq_mode_low_bits) == '0)
        else $error("reserved mode raised an event");

    bypass_path_a: assert property ((~q.gf_en & (det ^ q.sync2)) == '0)
        else $error("unfiltered pin not detected directly");

    glitch_drop_a: assert property (((q.filt ^ $past(q.filt)) & ($past(q.sync2, 2) ^ $past(q.sync2, 4))) == '0)
        else $error("filter passed a short pulse");

    gf_set_a: assert property (wr && grp == OFF_GF_EN && sub == SUB_SET && wb_sel_i == 4'hF
                               |=> (q.gf_en[$past(pb) +: 32] & $past(wb_dat_i)) == $past(wb_dat_i))
        else $error("filter enable set write lost bits");

    irq_group_a: assert property (q.irq[0] == $past(|(q.flags[GRPSIZE-1:0] & q.irq_en[GRPSIZE-1:0])))
        else $error("group request does not follow flags and enables");

    ack_pulse_a: assert property (req && !q.ack |=> q.ack ##1 !q.ack)
        else $error("bus ack not a single cycle");

endmodule // gpf_top

`default_nettype wire

// ---- dv/gpf_pin_model.sv ----
// Pad and peripheral model on the far side of the pin controller
`timescale 1ns/1ns
`default_nettype none

module gpf_pin_model
(
    input  wire logic [gpf_pkg::NPIN-1:0] ext_lvl,
    input  wire logic [gpf_pkg::NPIN-1:0] pin_out,
    input  wire logic [gpf_pkg::NPIN-1:0] pin_oe_b,
    output logic      [gpf_pkg::NPIN-1:0] pin_in,
    output var gpf_pkg::gpf_periph_s      periph
);
    import gpf_pkg::*;

    // Controller wins where it drives, otherwise the outside level is seen
    assign pin_in = (pin_out & ~pin_oe_b) | (ext_lvl & pin_oe_b);

    // Function f repeats its own number, so a wrong select shows on bits 1:0
    always_comb begin
        for (int f = 0; f < NFUNC; f++) begin
            periph.dout[f] = {(NPIN/2){f[1:0]}};
            periph.den[f]  = '1;
        end
    end
endmodule // gpf_pin_model

`default_nettype wire

// ---- dv/tb_gpf_top.sv ----
// Self-checking bench of the pin interrupt and mux controller
`timescale 1ns/1ns
`default_nettype none

module tb_gpf_top;
    import gpf_pkg::*;

    logic              clk_sys, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [WB_AW-1:0]  wb_adr_i;
    logic [31:0]       wb_dat_i, wb_dat_o, rd_q;
    logic [3:0]        wb_sel_i;
    logic [NPIN-1:0]   pin_in, pin_out, pin_oe_b, ext_lvl, periph_din;
    logic [NIRQ-1:0]   irq_o;
    gpf_periph_s       periph;
    int                n_fail, num_checks;

    gpf_top gpf_top_inst (.clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_b(pin_oe_b), .periph_i(periph),
        .periph_din(periph_din), .irq_o(irq_o));
    gpf_pin_model gpf_pin_model_inst (.ext_lvl(ext_lvl), .pin_out(pin_out), .pin_oe_b(pin_oe_b),
        .pin_in(pin_in), .periph(periph));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    function automatic logic [9:0] ad(input logic [1:0] p, input logic [7:0] o, input logic [1:0] s);
        return {p, o} | {6'h00, s, 2'h0};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Classic single cycle; only the watchdog ends a hung wait
    task automatic wb(input logic we, input logic [9:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_sys);
        end while (wb_ack_o !== 1'b1);
        rd_q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0000_0000);
        chk(rd_q, exp);
    endtask

    task automatic pulse(input logic v, input int n);
        ext_lvl[0] <= v;
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic t_reset();
        rdc(ad(0, OFF_GF_EN, SUB_RW), RST_EN_P02);
        rdc(ad(3, OFF_GF_EN, SUB_RW), RST_EN_P3);
        rdc(ad(2, OFF_SW_CTRL, SUB_RW), RST_EN_P02);
        rdc(ad(3, OFF_SW_CTRL, SUB_RW), RST_EN_P3);
        rdc(ad(0, OFF_IRQ_EN, SUB_RW), 32'h0000_0000);
        rdc(ad(1, OFF_FLAGS, SUB_RW), 32'h0000_0000);
        chk({16'h0000, irq_o}, 32'h0000_0000);
    endtask

    task automatic t_gf();
        wb(1'b1, ad(0, OFF_GF_EN, SUB_RW), 32'h0000_00F0);
        wb(1'b1, ad(0, OFF_GF_EN, SUB_SET), 32'h0000_000F);
        rdc(ad(0, OFF_GF_EN, SUB_RW), 32'h0000_00FF);
        wb(1'b1, ad(0, OFF_GF_EN, SUB_CLR), 32'h0000_0011);
        rdc(ad(0, OFF_GF_EN, SUB_RW), 32'h0000_00EE);
        wb(1'b1, ad(0, OFF_GF_EN, SUB_TGL), 32'h0000_0103);
        rdc(ad(0, OFF_GF_EN, SUB_RW), 32'h0000_01ED);
        wb(1'b1, ad(0, OFF_GF_EN, SUB_CLR), 32'h0000_0001);
        // Only byte 1 may change under a partial select
        wb_sel_i <= 4'h2;
        wb(1'b1, ad(1, OFF_GF_EN, SUB_RW), 32'h0000_0000);
        wb_sel_i <= 4'hF;
        rdc(ad(1, OFF_GF_EN, SUB_RW), 32'h0FFF_00FF);
    endtask

    task automatic set_mode(input logic [1:0] m);
        wb(1'b1, ad(0, OFF_MODE_HI, SUB_RW), {31'h0, m[1]});
        wb(1'b1, ad(0, OFF_MODE_LO, SUB_RW), {31'h0, m[0]});
        wb(1'b1, ad(0, OFF_FLAGS_CLR, SUB_RW), 32'hFFFF_FFFF);
    endtask

    task automatic t_modes();
        logic r, f;
        wb(1'b1, ad(0, OFF_IRQ_EN, SUB_RW), 32'h0000_0001);
        for (int m = 0; m < 4; m++) begin
            r = (m == 0) || (m == 1);
            f = (m == 0) || (m == 2);
            set_mode(m[1:0]);
            pulse(1'b1, 10);
            rdc(ad(0, OFF_FLAGS, SUB_RW), {31'h0, r});
            chk({31'h0, irq_o[0]}, {31'h0, r});
            chk({31'h0, periph_din[0]}, 32'h0000_0001);
            wb(1'b1, ad(0, OFF_FLAGS_CLR, SUB_RW), 32'h0000_0001);
            pulse(1'b0, 10);
            rdc(ad(0, OFF_FLAGS, SUB_RW), {31'h0, f});
        end
    endtask

    task automatic t_sticky();
        set_mode(MODE_CHANGE);
        pulse(1'b1, 10);
        wb(1'b1, ad(0, OFF_FLAGS, SUB_RW), 32'h0000_0001);
        repeat (20) @(posedge clk_sys);
        rdc(ad(0, OFF_FLAGS, SUB_RW), 32'h0000_0001);
        wb(1'b1, ad(0, OFF_FLAGS_CLR, SUB_RW), 32'h0000_0001);
        rdc(ad(0, OFF_FLAGS, SUB_RW), 32'h0000_0000);
        chk({31'h0, irq_o[0]}, 32'h0000_0000);
        // Filter is changed only while the pin's interrupt is off
        wb(1'b1, ad(0, OFF_IRQ_EN, SUB_CLR), 32'h0000_0001);
        pulse(1'b0, 10);
        rdc(ad(0, OFF_FLAGS, SUB_RW), 32'h0000_0000);
        wb(1'b1, ad(0, OFF_GF_EN, SUB_SET), 32'h0000_0001);
        wb(1'b1, ad(0, OFF_IRQ_EN, SUB_SET), 32'h0000_0001);
        set_mode(MODE_RISE);
        pulse(1'b1, 2);
        pulse(1'b0, 12);
        rdc(ad(0, OFF_FLAGS, SUB_RW), 32'h0000_0000);
        pulse(1'b1, 6);
        pulse(1'b0, 12);
        rdc(ad(0, OFF_FLAGS, SUB_RW), 32'h0000_0001);
    endtask

    task automatic t_mux();
        wb(1'b1, ad(0, OFF_DRV_EN, SUB_CLR), 32'h0000_0001);
        wb(1'b1, ad(0, OFF_SW_CTRL, SUB_SET), 32'h0000_0001);
        wb(1'b1, ad(0, OFF_PSEL_LO, SUB_SET), 32'h0000_0001);
        wb(1'b1, ad(0, OFF_PSEL_HI, SUB_CLR), 32'h0000_0001);
        wb(1'b1, ad(0, OFF_SW_CTRL, SUB_CLR), 32'h0000_0001);
        repeat (3) @(posedge clk_sys);
        chk({30'h0, pin_out[0], pin_oe_b[0]}, 32'h0000_0002);
        wb(1'b1, ad(0, OFF_PSEL_LO, SUB_CLR), 32'h0000_0001);
        wb(1'b1, ad(0, OFF_PSEL_HI, SUB_SET), 32'h0000_0001);
        repeat (3) @(posedge clk_sys);
        chk({30'h0, pin_out[0], pin_oe_b[0]}, 32'h0000_0000);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        n_fail++;
        wrap_up();
    end

    initial begin
        n_fail = 0;
        num_checks = 0;
        rst_b = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_sel_i = 4'hF;
        wb_adr_i = '0;
        wb_dat_i = 32'h0000_0000;
        ext_lvl = '0;
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset();
        t_gf();
        t_modes();
        t_sticky();
        t_mux();
        wrap_up();
    end
endmodule // tb_gpf_top

`default_nettype wire
